// ---- src/bank_decode.v ----
`default_nettype none
`include "bank_strobe_consts.vh"

module bank_decode (
    input  wire [7:0] ctl,
    input  wire [1:0] bank_bits,
    output reg  [1:0] bank_bits_out,
    output reg  [2:0] waits,
    output reg  [2:0] cs_sel,
    output reg        pair_b,
    output reg        write_ok
);

    // Pure decode of one bank control byte
    always @* begin
        bank_bits_out = bank_bits ^
            {ctl[`INV_MSB], ctl[`INV_LSB]};
        case (ctl[`WS_HI:`WS_LO])
            2'h0:    waits = `WAITS_00;
            2'h1:    waits = `WAITS_01;
            2'h2:    waits = `WAITS_10;
            default: waits = `WAITS_11;
        endcase
        // Low code bit picks the pair, high bit blocks writes
        pair_b   = ctl[`STB_LO];
        write_ok = ~ctl[`STB_HI];
        // Reserved code selects nothing rather than guess
        case (ctl[`CS_HI:`CS_LO])
            `CS_CODE_A: cs_sel = 3'h1;
            `CS_CODE_B: cs_sel = 3'h2;
            `CS_CODE_C: cs_sel = 3'h4;
            default:    cs_sel = 3'h0;
        endcase
    end

endmodule // bank_decode
`default_nettype wire

// ---- src/bank_strobe_consts.vh ----
`ifndef BANK_STROBE_CONSTS_VH
`define BANK_STROBE_CONSTS_VH

// Register indices; byte address is four times the index
`define IDX_BANK0     8'h14
`define IDX_BANK1     8'h15
`define IDX_BANK2     8'h16
`define IDX_BANK3     8'h17
`define IDX_XCODE     8'h18
`define IDX_TIMING    8'h19
`define IDX_STATUS    8'h1A

// Bank control fields
`define WS_HI         7
`define WS_LO         6
`define INV_MSB       5
`define INV_LSB       4
`define STB_HI        3
`define STB_LO        2
`define CS_HI         1
`define CS_LO         0
`define WAITS_00      3'h4
`define WAITS_01      3'h2
`define WAITS_10      3'h1
`define WAITS_11      3'h0
`define WRITE_EXTRA   3'h1
`define CS_CODE_A     2'h0
`define CS_CODE_B     2'h1
`define CS_CODE_C     2'h2

// Override and timing fields
`define XCODE_EN      2
`define XCODE_W       3
`define TIM_W         4
`define TIM_WE_A      0
`define TIM_OE_A      2

// Status fields
`define ST_BUSY       0
`define ST_BANK_LO    1
`define ST_BANK_HI    2

// Reset values
`define BANK_RESET    8'h00
`define XCODE_RESET   3'h0
`define TIMING_RESET  4'h0
`define RDATA_ZERO    32'h0000_0000

`endif

// ---- src/memory_bank_strobe_control.v ----
`default_nettype none
`include "bank_strobe_consts.vh"

module memory_bank_strobe_control #(
    parameter ADDR_W = 20
) (
    input  wire              clock,
    input  wire              rst_n,
    // Avalon-MM register slave, word addressed
    input  wire [7:0]        address,
    input  wire              read,
    input  wire              write,
    input  wire [31:0]       writedata,
    input  wire [3:0]        byteenable,
    output reg  [31:0]       readdata,
    output wire              waitrequest,
    // Memory access request from the processor core
    input  wire              mem_req,
    input  wire              mem_write,
    input  wire              mem_xcode,
    input  wire [ADDR_W-1:0] mem_addr,
    output wire              mem_done,
    // External memory pins
    output reg  [ADDR_W-1:0] ext_addr,
    output wire              chip_select_a_n,
    output wire              chip_select_b_n,
    output wire              chip_select_c_n,
    output wire              output_enable_a_n,
    output wire              output_enable_b_n,
    output wire              write_enable_a_n,
    output wire              write_enable_b_n
);

    localparam ST_IDLE   = 1'b0;
    localparam ST_ACCESS = 1'b1;

    reg                  rst_meta;
    reg                  rst_sync_n;
    reg  [7:0]           bank_ctl [0:3];
    reg  [`XCODE_W-1:0]  xcode;
    reg  [`TIM_W-1:0]    timing;
    reg                  ack;
    reg                  state;
    reg  [2:0]           cnt;
    reg  [2:0]           lat_cs;
    reg                  lat_pair_b;
    reg                  lat_write_ok;
    reg                  lat_write;
    reg  [1:0]           last_bank;
    reg  [2:0]           cs_pos;
    reg  [1:0]           oe_pos;
    reg  [1:0]           we_pos;
    reg  [1:0]           oe_early;
    reg  [1:0]           we_early;
    reg  [2:0]           next_cs;
    reg  [1:0]           next_oe;
    reg  [1:0]           next_we;
    reg                  next_busy;
    reg                  nx_pair_b;
    reg                  nx_write;
    reg                  nx_write_ok;
    wire                 start;
    wire                 access_last;
    wire [1:0]           req_bank;
    wire [7:0]           req_ctl;
    wire [1:0]           dec_bits;
    wire [2:0]           dec_waits;
    wire [2:0]           dec_cs;
    wire                 dec_pair_b;
    wire                 dec_write_ok;
    wire                 bus_req;
    wire                 reg_wr;
    wire [2:0]           total_waits;

    // Register index decode, shared by the read mux and the write decode
    function is_bank_idx;
        input [7:0] idx;
        begin
            is_bank_idx = (idx >= `IDX_BANK0) && (idx <= `IDX_BANK3);
        end
    endfunction

    // Reset release through two flops; assertion stays asynchronous
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta   <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta   <= 1'b1;
            rst_sync_n <= rst_meta;
        end
    end

    // One wait cycle per bus access gives the read mux a flop stage
    assign bus_req     = read | write;
    assign waitrequest = bus_req & ~ack;
    assign reg_wr      = write & ack & byteenable[0];

    always @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            ack <= 1'b0;
        end else begin
            ack <= bus_req & ~ack;
        end
    end

    // Register writes land on the edge where the master sees waitrequest low
    always @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            bank_ctl[0] <= `BANK_RESET;
            bank_ctl[1] <= `BANK_RESET;
            bank_ctl[2] <= `BANK_RESET;
            bank_ctl[3] <= `BANK_RESET;
            xcode       <= `XCODE_RESET;
            timing      <= `TIMING_RESET;
        end else if (reg_wr) begin
            if (is_bank_idx(address)) begin
                bank_ctl[address[1:0]] <= writedata[7:0];
            end
            // Upper bits are not stored, so they read back zero
            if (address == `IDX_XCODE) begin
                xcode <= writedata[`XCODE_W-1:0];
            end
            // Reserved upper timing bits are left to software
            if (address == `IDX_TIMING) begin
                timing <= writedata[`TIM_W-1:0];
            end
        end
    end

    // Read data is captured in the waiting cycle
    always @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            readdata <= `RDATA_ZERO;
        end else if (read & ~ack) begin
            readdata <= `RDATA_ZERO;
            if (is_bank_idx(address)) begin
                readdata[7:0] <= bank_ctl[address[1:0]];
            end else if (address == `IDX_XCODE) begin
                readdata[`XCODE_W-1:0] <= xcode;
            end else if (address == `IDX_TIMING) begin
                readdata[`TIM_W-1:0] <= timing;
            end else if (address == `IDX_STATUS) begin
                readdata[`ST_BUSY] <= state;
                readdata[`ST_BANK_HI:`ST_BANK_LO] <= last_bank;
            end
        end
    end

    // Override codes 001-011 are ignored like normal operation
    assign req_bank = (mem_xcode & xcode[`XCODE_EN]) ?
        xcode[1:0] :
        mem_addr[ADDR_W-1:ADDR_W-2];
    assign req_ctl  = bank_ctl[req_bank];

    bank_decode u_decode (
        .ctl           (req_ctl),
        .bank_bits     (mem_addr[ADDR_W-1:ADDR_W-2]),
        .bank_bits_out (dec_bits),
        .waits         (dec_waits),
        .cs_sel        (dec_cs),
        .pair_b        (dec_pair_b),
        .write_ok      (dec_write_ok)
    );

    // Writes hold the strobe one clock longer than reads
    assign total_waits = mem_write ?
        (dec_waits + `WRITE_EXTRA) : dec_waits;

    assign start       = (state == ST_IDLE) & mem_req;
    assign access_last = (state == ST_ACCESS) & (cnt == 3'h0);
    assign mem_done    = access_last;

    // Access sequencer: cnt holds the clocks left after this one
    always @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            state        <= ST_IDLE;
            cnt          <= 3'h0;
            lat_cs       <= 3'h0;
            lat_pair_b   <= 1'b0;
            lat_write_ok <= 1'b0;
            lat_write    <= 1'b0;
            last_bank    <= 2'h0;
            ext_addr     <= {ADDR_W{1'b0}};
        end else begin
            case (state)
                ST_IDLE: begin
                    if (mem_req) begin
                        state        <= ST_ACCESS;
                        cnt          <= total_waits;
                        lat_cs       <= dec_cs;
                        lat_pair_b   <= dec_pair_b;
                        lat_write_ok <= dec_write_ok;
                        lat_write    <= mem_write;
                        last_bank    <= req_bank;
                        ext_addr     <= {dec_bits,
                            mem_addr[ADDR_W-3:0]};
                    end
                end
                ST_ACCESS: begin
                    if (cnt == 3'h0) begin
                        state <= ST_IDLE;
                    end else begin
                        cnt <= cnt - 3'h1;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // Strobe values for the coming clock, from request or latch
    always @* begin
        next_busy   = start | ((state == ST_ACCESS) & (cnt != 3'h0));
        nx_pair_b   = start ? dec_pair_b   : lat_pair_b;
        nx_write    = start ? mem_write    : lat_write;
        nx_write_ok = start ? dec_write_ok : lat_write_ok;
        next_cs     = 3'h0;
        next_oe     = 2'h0;
        next_we     = 2'h0;
        if (next_busy) begin
            next_cs = start ? dec_cs : lat_cs;
            // Read-only banks keep the cycle but drop the write
            if (!nx_write) begin
                next_oe = nx_pair_b ? 2'h2 : 2'h1;
            end else if (nx_write_ok) begin
                next_we = nx_pair_b ? 2'h2 : 2'h1;
            end
        end
    end

    // Rising-edge copies frame the normal strobe window
    always @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            cs_pos <= 3'h0;
            oe_pos <= 2'h0;
            we_pos <= 2'h0;
        end else begin
            cs_pos <= next_cs;
            oe_pos <= next_oe;
            we_pos <= next_we;
        end
    end

    // Falling-edge copies lead the rising ones by half a clock
    always @(negedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            oe_early <= 2'h0;
            we_early <= 2'h0;
        end else begin
            oe_early <= next_oe;
            we_early <= next_we;
        end
    end

    // Chip selects follow the rising-edge window only
    assign chip_select_a_n = ~cs_pos[0];
    assign chip_select_b_n = ~cs_pos[1];
    assign chip_select_c_n = ~cs_pos[2];

    // Extended read enable starts early, still ends on a rising edge
    assign output_enable_a_n = ~(oe_pos[0] |
        (timing[`TIM_OE_A] & oe_early[0]));
    assign output_enable_b_n = ~(oe_pos[1] |
        (timing[`TIM_OE_A+1] & oe_early[1]));

    // Normal write ends half a clock early so data hold is kept;
    // extended write shifts the whole window to falling edges
    assign write_enable_a_n = ~(timing[`TIM_WE_A] ?
        we_early[0] : (we_pos[0] & we_early[0]));
    assign write_enable_b_n = ~(timing[`TIM_WE_A+1] ?
        we_early[1] : (we_pos[1] & we_early[1]));

endmodule // memory_bank_strobe_control
`default_nettype wire

// ---- tb/bank_strobe_props.sv ----
`default_nettype none
module bank_strobe_props #(
    parameter ADDR_W = 20
) (
    input wire logic              clock,
    input wire logic              rst_n,
    input wire logic              read,
    input wire logic              waitrequest,
    input wire logic [31:0]       readdata,
    input wire logic              mem_req,
    input wire logic              mem_write,
    input wire logic              mem_done,
    input wire logic [ADDR_W-1:0] ext_addr,
    input wire logic              chip_select_a_n,
    input wire logic              chip_select_b_n,
    input wire logic              chip_select_c_n,
    input wire logic              output_enable_a_n,
    input wire logic              output_enable_b_n,
    input wire logic              write_enable_a_n,
    input wire logic              write_enable_b_n
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    // Pins grouped for the idle and exclusivity checks
    wire [2:0] cs_n = {chip_select_c_n, chip_select_b_n, chip_select_a_n};
    wire [3:0] st_n = {output_enable_a_n, output_enable_b_n,
                       write_enable_a_n, write_enable_b_n};

    property p_reg_answer;
        $rose(read) |-> waitrequest ##1 !waitrequest;
    endproperty
    a_reg_answer: assert property (p_reg_answer)
        else $error("register answer not one cycle after request");
    property p_rdata_hold;
        !read |=> $stable(readdata);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold)
        else $error("readdata changed without a read");
    property p_done_bound;
        $rose(mem_req) |-> ##[1:6] mem_done;
    endproperty
    a_done_bound: assert property (p_done_bound)
        else $error("access longer than the longest wait setting");
    property p_done_pulse;
        mem_done |=> !mem_done;
    endproperty
    a_done_pulse: assert property (p_done_pulse)
        else $error("access end held more than one clock");
    property p_idle_pins;
        !mem_req |-> (&cs_n) && (&st_n);
    endproperty
    a_idle_pins: assert property (p_idle_pins)
        else $error("select or strobe active with no access");
    property p_one_cs;
        $onehot0(~cs_n);
    endproperty
    a_one_cs: assert property (p_one_cs)
        else $error("more than one chip select active");
    property p_rd_no_we;
        mem_req && !mem_write |-> write_enable_a_n && write_enable_b_n;
    endproperty
    a_rd_no_we: assert property (p_rd_no_we)
        else $error("write strobe during a read");
    property p_wr_no_oe;
        mem_req && mem_write |-> output_enable_a_n && output_enable_b_n;
    endproperty
    a_wr_no_oe: assert property (p_wr_no_oe)
        else $error("output enable during a write");
    property p_addr_hold;
        !mem_req |=> $stable(ext_addr);
    endproperty
    a_addr_hold: assert property (p_addr_hold)
        else $error("memory address moved while idle");
endmodule // bank_strobe_props

bind memory_bank_strobe_control bank_strobe_props #(.ADDR_W(ADDR_W)) chk (
    .clock(clock), .rst_n(rst_n), .read(read), .waitrequest(waitrequest),
    .readdata(readdata), .mem_req(mem_req), .mem_write(mem_write),
    .mem_done(mem_done), .ext_addr(ext_addr),
    .chip_select_a_n(chip_select_a_n), .chip_select_b_n(chip_select_b_n),
    .chip_select_c_n(chip_select_c_n),
    .output_enable_a_n(output_enable_a_n),
    .output_enable_b_n(output_enable_b_n),
    .write_enable_a_n(write_enable_a_n), .write_enable_b_n(write_enable_b_n));
`default_nettype wire

// ---- tb/ext_mem_model.sv ----
`default_nettype none
module ext_mem_model (
    input wire logic        clock,
    input wire logic        clr,
    input wire logic [2:0]  cs_n,
    input wire logic [3:0]  st_n,
    output var logic [6:0]  seen
);
    timeunit 1ns;
    timeprecision 1ns;
    // Chips note every pin pulled low; no data path is modelled
    always @(clock) begin
        if (clr)
            seen <= 7'h00;
        else
            seen <= seen | ~{cs_n, st_n};
    end
endmodule // ext_mem_model
`default_nettype wire

// ---- tb/memory_bank_strobe_control_tb_top.sv ----
`default_nettype none
module memory_bank_strobe_control_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clock, rst_n, read, write, mem_req, mem_write, mem_xcode, clr;
    logic [7:0]  address, c;
    logic [31:0] writedata, readdata, q;
    logic [3:0]  byteenable, tm;
    logic [6:0]  p, e, g;
    logic [19:0] mem_addr, ext_addr;
    logic [7:0]  bank_ctl [4];
    wire         waitrequest, mem_done;
    wire  [2:0]  cs_n;
    wire  [3:0]  st_n;
    wire  [6:0]  seen;
    int          errors, check_count, cyc, n;

    memory_bank_strobe_control dut (.clock(clock), .rst_n(rst_n),
        .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .mem_req(mem_req), .mem_write(mem_write),
        .mem_xcode(mem_xcode), .mem_addr(mem_addr), .mem_done(mem_done),
        .ext_addr(ext_addr), .chip_select_a_n(cs_n[0]),
        .chip_select_b_n(cs_n[1]), .chip_select_c_n(cs_n[2]),
        .output_enable_a_n(st_n[0]), .output_enable_b_n(st_n[1]),
        .write_enable_a_n(st_n[2]), .write_enable_b_n(st_n[3]));
    ext_mem_model mem (.clock(clock), .clr(clr), .cs_n(cs_n), .st_n(st_n),
        .seen(seen));

    // 10 MHz clock
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    // Hang guard; the full run needs well under a thousand clocks
    always @(posedge clock) begin
        cyc++;
        if (cyc == 5000) begin
            errors++;
            end_sim;
        end
    end

    task automatic end_sim;
        if (errors == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        check_count++;
        if (g !== e) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Avalon access: hold until a rising edge sees waitrequest low
    task automatic reg_acc(logic w, logic [7:0] a, logic [7:0] d,
                           logic [3:0] be);
        @(posedge clock);
        address <= a;
        writedata <= {24'h000000, d};
        byteenable <= be;
        read <= !w;
        write <= w;
        do @(posedge clock); while (waitrequest !== 1'b0);
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask
    task automatic rchk(logic [7:0] a, logic [31:0] e);
        reg_acc(1'b0, a, 8'h00, 4'hF);
        chk($sformatf("register %h", a), e, q);
    endtask
    function automatic int waits(logic [1:0] f);
        return f == 2'h0 ? 4 : f == 2'h1 ? 2 : f == 2'h2 ? 1 : 0;
    endfunction
    // Pins expected low: {cs c,b,a, we b,a, oe b,a}
    function automatic logic [6:0] pins(logic [7:0] k, logic w);
        return {k[1:0] == 2'h2, k[1:0] == 2'h1, k[1:0] == 2'h0,
                w && k[3:2] == 2'h1, w && k[3:2] == 2'h0,
                !w && k[2], !w && !k[2]};
    endfunction
    // One memory access; length, pins and bank bits against control k
    task automatic acc(logic w, logic x, logic [1:0] top, logic [7:0] k);
        @(posedge clock);
        mem_req <= 1'b1;
        mem_write <= w;
        mem_xcode <= x;
        mem_addr <= {top, 18'h2A5C3};
        clr <= 1'b1;
        @(posedge clock);
        clr <= 1'b0;
        // Only stretched strobes may be low before the first access edge
        p = pins(k, w);
        e = {3'h0, p[3:0] & {tm[1], tm[0], tm[3], tm[2]}};
        g = ~{cs_n, st_n};
        chk("early pins", e, g);
        n = 0;
        do begin
            @(negedge clock);
            n++;
        end while (mem_done !== 1'b1 && n < 9);
        @(posedge clock);
        mem_req <= 1'b0;
        @(negedge clock);
        chk("access clocks", 1 + w + waits(k[7:6]), n);
        chk("pins", pins(k, w), seen);
        chk("bank bits", top ^ k[5:4], ext_addr[19:18]);
    endtask

    initial begin
        {rst_n, read, write, mem_req, mem_write, mem_xcode, clr} = 7'h00;
        tm = 4'h0;
        address = 8'h00;
        writedata = 32'h00000000;
        byteenable = 4'hF;
        mem_addr = 20'h00000;
        repeat (20) @(posedge clock);
        rst_n <= 1'b1;
        repeat (3) @(posedge clock);
        // Reset values, override register readback, unmapped and disabled writes
        for (int i = 0; i < 6; i++) rchk(8'(8'h14 + i), 32'h0);
        reg_acc(1'b1, 8'h18, 8'h07, 4'hF);
        rchk(8'h18, 32'h7);
        reg_acc(1'b1, 8'h30, 8'h5A, 4'hF);
        rchk(8'h30, 32'h0);
        reg_acc(1'b1, 8'h15, 8'h5A, 4'h0);
        rchk(8'h15, 32'h0);
        reg_acc(1'b1, 8'h18, 8'h00, 4'hF);
        // Every wait, inversion and strobe code, select codes 0-2, read and write
        for (int k = 0; k < 8; k++) begin
            c = {k[1:0], k[2], k[0], k[2:1], 2'(k % 3)};
            bank_ctl[k[1:0]] = c;
            reg_acc(1'b1, 8'h14 + k[1:0], c, 4'hF);
            rchk(8'h14 + k[1:0], {24'h0, c});
            acc(1'b0, 1'b0, k[1:0], c);
            acc(1'b1, 1'b0, k[1:0], c);
        end
        // Window override onto each bank, ignoring the address bits
        for (int j = 0; j < 4; j++) begin
            reg_acc(1'b1, 8'h18, 8'(8'h04 + j), 4'hF);
            acc(1'b0, 1'b1, 2'(j + 1), bank_ctl[j]);
            rchk(8'h1A, 32'(2 * j));
        end
        acc(1'b0, 1'b0, 2'h1, bank_ctl[1]);
        reg_acc(1'b1, 8'h18, 8'h00, 4'hF);
        acc(1'b0, 1'b1, 2'h2, bank_ctl[2]);
        rchk(8'h1A, 32'h4);
        // Stretched strobes must not change which pins fire
        reg_acc(1'b1, 8'h19, 8'h0F, 4'hF);
        tm = 4'hF;
        rchk(8'h19, 32'hF);
        acc(1'b0, 1'b0, 2'h3, bank_ctl[3]);
        acc(1'b1, 1'b0, 2'h0, bank_ctl[0]);
        end_sim;
    end
endmodule // memory_bank_strobe_control_tb_top
`default_nettype wire
